// ---- pcts_trigger_select.v ----
`timescale 1ns/10ps
`include "pcts_defs.vh"
module pcts_trigger_select (
  input wire clk_i, // 250 MHz system clock.
  input wire rst_i, // Synchronous reset, active high.
  input wire wb_cyc_i, // Wishbone cycle.
  input wire wb_stb_i, // Wishbone strobe.
  input wire wb_we_i, // Wishbone write enable.
  input wire [3:0] wb_adr_i, // Byte address.
  input wire [3:0] wb_sel_i, // Byte lane selects.
  input wire [31:0] wb_dat_i, // Write data.
  output reg [31:0] wb_dat_o, // Read data.
  output reg wb_ack_o, // Access acknowledge.
  input wire [15:0] carrier_counter_i, // Carrier counter value.
  input wire count_up_i, // High while the carrier counts up.
  input wire carrier_peak_i, // One-cycle pulse at the carrier peak.
  input wire carrier_bottom_i, // One-cycle pulse at the carrier bottom.
  input wire triangle_mode_i, // High for triangle carrier, low for sawtooth.
  input wire emergency_protection_i, // High while protection is active.
  output reg conversion_start_pulse0_o, // Slot-0 trigger pulse.
  output reg conversion_start_pulse1_o // Slot-1 trigger pulse.
);

  reg [15:0] trigger_slot_control;
  reg [1:0] fault_trigger_register;
  reg [15:0] buf0;
  reg [15:0] buf1;
  reg [15:0] trigger_compare_slot0;
  reg [15:0] trigger_compare_slot1;
  reg [15:0] last_cnt;
  reg last_up;
  reg first_seen;

  wire [2:0] slot0_match_mode = trigger_slot_control[`PCTS_S0_MODE_LSB +: 3];
  wire [2:0] slot1_match_mode = trigger_slot_control[`PCTS_S1_MODE_LSB +: 3];
  wire slot0_immediate_load = trigger_slot_control[`PCTS_S0_IMM_BIT];
  wire slot1_immediate_load = trigger_slot_control[`PCTS_S1_IMM_BIT];
  wire fault_trigger_enable = fault_trigger_register[`PCTS_FAULT_EN_BIT];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;

  // In sawtooth mode down-match becomes up-match and bottom becomes peak.
  function [2:0] eff_mode;
    input [2:0] md;
    input tri_m;
    begin
      if (!tri_m && md == `PCTS_MD_DOWN) begin
        eff_mode = `PCTS_MD_UP;
      end else if (!tri_m && md == `PCTS_MD_BOTTOM) begin
        eff_mode = `PCTS_MD_PEAK;
      end else begin
        eff_mode = md;
      end
    end
  endfunction

  // Decides whether a slot fires this cycle.
  function fire;
    input [2:0] md;
    input [15:0] cmp;
    input [15:0] cnt;
    input up;
    input pk;
    input bt;
    input tri_m;
    input fresh;
    reg hit;
    begin
      hit = (cmp == cnt) & fresh;
      case (md)
        `PCTS_MD_DOWN: fire = hit & ~up;
        `PCTS_MD_UP: fire = hit & up;
        // At 0x0001 a triangle carrier passes the value twice around the bottom; fire only up.
        `PCTS_MD_BOTH: fire = hit & (~tri_m | cmp != `PCTS_CMP_ONE | up);
        `PCTS_MD_PEAK: fire = pk;
        `PCTS_MD_BOTTOM: fire = bt;
        `PCTS_MD_PK_BT: fire = pk | bt;
        default: fire = 1'b0;
      endcase
    end
  endfunction

  // Sync-point decision for a buffered compare value.
  function load_now;
    input [2:0] md;
    input pk;
    input bt;
    begin
      case (md)
        `PCTS_MD_DOWN: load_now = pk;
        `PCTS_MD_UP: load_now = bt;
        `PCTS_MD_BOTH: load_now = pk | bt;
        default: load_now = 1'b1;
      endcase
    end
  endfunction

  wire [2:0] m0 = eff_mode(slot0_match_mode, triangle_mode_i);
  wire [2:0] m1 = eff_mode(slot1_match_mode, triangle_mode_i);
  // A counter that stays on one value would otherwise fire every cycle.
  wire fresh = ~first_seen | (carrier_counter_i != last_cnt) | (count_up_i != last_up);
  wire gate = ~emergency_protection_i | fault_trigger_enable;

  // Register writes and compare loading.
  always @(posedge clk_i) begin
    if (rst_i) begin
      trigger_slot_control <= `PCTS_CTRL_RST;
      fault_trigger_register <= `PCTS_FAULT_RST;
      buf0 <= `PCTS_CMP_RST;
      buf1 <= `PCTS_CMP_RST;
      trigger_compare_slot0 <= `PCTS_CMP_RST;
      trigger_compare_slot1 <= `PCTS_CMP_RST;
    end else begin
      if (wr && wb_adr_i == `PCTS_ADDR_CTRL) begin
        if (wb_sel_i[0]) trigger_slot_control[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) trigger_slot_control[15:8] <= wb_dat_i[15:8];
      end
      if (wr && wb_adr_i == `PCTS_ADDR_FAULT && wb_sel_i[0]) begin
        fault_trigger_register <= wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == `PCTS_ADDR_CMP0) begin
        if (wb_sel_i[0]) buf0[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) buf0[15:8] <= wb_dat_i[15:8];
      end
      if (wr && wb_adr_i == `PCTS_ADDR_CMP1) begin
        if (wb_sel_i[0]) buf1[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) buf1[15:8] <= wb_dat_i[15:8];
      end
      // Active values follow the buffer one cycle after a write at the earliest.
      if (slot0_immediate_load || load_now(m0, carrier_peak_i, carrier_bottom_i)) begin
        trigger_compare_slot0 <= buf0;
      end
      if (slot1_immediate_load || load_now(m1, carrier_peak_i, carrier_bottom_i)) begin
        trigger_compare_slot1 <= buf1;
      end
    end
  end

  // Trigger pulses, each one clock wide.
  always @(posedge clk_i) begin
    if (rst_i) begin
      conversion_start_pulse0_o <= 1'b0;
      conversion_start_pulse1_o <= 1'b0;
      last_cnt <= 16'h0000;
      last_up <= 1'b0;
      first_seen <= 1'b0;
    end else begin
      last_cnt <= carrier_counter_i;
      last_up <= count_up_i;
      first_seen <= 1'b1;
      conversion_start_pulse0_o <= gate & fire(m0, trigger_compare_slot0, carrier_counter_i,
        count_up_i, carrier_peak_i, carrier_bottom_i, triangle_mode_i, fresh);
      conversion_start_pulse1_o <= gate & fire(m1, trigger_compare_slot1, carrier_counter_i,
        count_up_i, carrier_peak_i, carrier_bottom_i, triangle_mode_i, fresh);
    end
  end

  // Single-wait-state slave; reads show the buffered compare values.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `PCTS_ADDR_CTRL: wb_dat_o <= {16'h0000, trigger_slot_control};
          `PCTS_ADDR_FAULT: wb_dat_o <= {30'h00000000, fault_trigger_register};
          `PCTS_ADDR_CMP0: wb_dat_o <= {16'h0000, buf0};
          `PCTS_ADDR_CMP1: wb_dat_o <= {16'h0000, buf1};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- pcts_defs.vh ----
// Summary of operation
// - With slot-1 immediate-load clear, a written slot-1 compare value waits in a buffer until its sync point; set, it applies at once.
// - Slot-0 immediate-load works the same way for the slot-0 compare value.
// - Slot-1 mode 000 disables, 001 fires on a down-count match, 010 on an up-count match, 011 on a match either way.
// - Slot-1 mode 100 fires at the carrier peak, 101 at the carrier bottom, 111 disables.
// - Slot-0 mode bits 2 to 0 use the same encoding as slot 1 on the slot-0 compare value.
// - In sawtooth carrier mode, down-match acts as up-match and bottom acts as peak, for both slots.
// - Match-either-way in triangle mode with compare value 0x0001 fires once per carrier cycle, not twice.
// - With the fault trigger enable clear, no trigger leaves while emergency protection is active; set, triggers continue.
// - A trigger fires when the active compare value equals the carrier counter in the direction or phase the mode selects.
// - Mode 110 fires at both the carrier peak and the carrier bottom.
// - Buffered values load at the peak for 001 (the bottom in sawtooth mode), the bottom for 010, peak or bottom for 011; other codes load at once.
`ifndef PCTS_DEFS_VH
`define PCTS_DEFS_VH
`define PCTS_ADDR_CTRL 4'h0
`define PCTS_ADDR_FAULT 4'h4
`define PCTS_ADDR_CMP0 4'h8
`define PCTS_ADDR_CMP1 4'hC
`define PCTS_CTRL_RST 16'h0000
`define PCTS_FAULT_RST 2'h0
`define PCTS_CMP_RST 16'h0000
`define PCTS_S0_MODE_LSB 0
`define PCTS_S0_IMM_BIT 3
`define PCTS_S1_MODE_LSB 4
`define PCTS_S1_IMM_BIT 7
`define PCTS_FAULT_EN_BIT 0
`define PCTS_MD_OFF 3'h0
`define PCTS_MD_DOWN 3'h1
`define PCTS_MD_UP 3'h2
`define PCTS_MD_BOTH 3'h3
`define PCTS_MD_PEAK 3'h4
`define PCTS_MD_BOTTOM 3'h5
`define PCTS_MD_PK_BT 3'h6
`define PCTS_MD_OFF2 3'h7
`define PCTS_CMP_ONE 16'h0001
`endif

// ---- pcts_trigger_select_properties.sv ----
`timescale 1ns/10ps
module pcts_trigger_select_properties (
  input wire clk_i, // System clock.
  input wire rst_i, // Synchronous reset.
  input wire wb_cyc_i, wb_stb_i, wb_we_i, // Bus request.
  input wire [3:0] wb_adr_i, wb_sel_i, // Address and lanes.
  input wire [31:0] wb_dat_i, wb_dat_o, // Bus data.
  input wire wb_ack_o, // Bus answer.
  input wire carrier_peak_i, carrier_bottom_i, triangle_mode_i, // Carrier state.
  input wire emergency_protection_i, // Protection active.
  input wire conversion_start_pulse0_o, conversion_start_pulse1_o // Trigger pulses.
);
  reg [7:0] c;
  reg f;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  // Shadow of the mode and gate bits; it updates on the edge the design takes a write.
  always @(posedge clk_i) begin
    if (rst_i) begin
      c <= 8'h00;
      f <= 1'b0;
    end else begin
      if (take && wb_adr_i == 4'h0) c <= wb_dat_i[7:0];
      if (take && wb_adr_i == 4'h4) f <= wb_dat_i[0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  read_high_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
    |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  pulse0_width_a: assert property (conversion_start_pulse0_o |=> !conversion_start_pulse0_o)
    else $error("slot 0 pulse too long");
  pulse1_width_a: assert property (conversion_start_pulse1_o |=> !conversion_start_pulse1_o)
    else $error("slot 1 pulse too long");
  slot0_off_a: assert property (conversion_start_pulse0_o
    |-> $past(c[2:0]) != 3'h0 && $past(c[2:0]) != 3'h7) else $error("disabled slot fired");
  peak0_fire_a: assert property ((c[2:0] == 3'h4 && carrier_peak_i && !emergency_protection_i)
    ##1 !emergency_protection_i |-> conversion_start_pulse0_o) else $error("peak missed");
  saw_bottom_a: assert property (c[6:4] == 3'h5 && !triangle_mode_i && carrier_bottom_i
    && !carrier_peak_i |=> !conversion_start_pulse1_o) else $error("sawtooth bottom fired");
  // A pulse is decided one edge earlier, so protection and the enable are judged there.
  emg_gate_a: assert property (conversion_start_pulse0_o || conversion_start_pulse1_o
    |-> !$past(emergency_protection_i) || $past(f))
    else $error("trigger during protection");
endmodule
bind pcts_trigger_select pcts_trigger_select_properties i_pcts_trigger_select_properties (.*);

// ---- pcts_adc_model.sv ----
`timescale 1ns/10ps
module pcts_adc_model (
  input wire clk_i, // System clock.
  input wire rst_i, // Synchronous reset.
  input wire start0_i, // Slot-0 start pulse.
  input wire start1_i, // Slot-1 start pulse.
  output reg [7:0] count0_o, // Conversions begun by slot 0.
  output reg [7:0] count1_o // Conversions begun by slot 1.
);
  // Every high cycle starts one conversion, so a stretched pulse shows as extra counts.
  always @(posedge clk_i) begin
    if (rst_i) begin
      count0_o <= 8'h00;
      count1_o <= 8'h00;
    end else begin
      count0_o <= count0_o + {7'h00, start0_i};
      count1_o <= count1_o + {7'h00, start1_i};
    end
  end
endmodule

// ---- pcts_trigger_select_bench.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module pcts_trigger_select_bench;
  reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, up = 1, pk = 0, bt = 0, tri_m = 1, emergency_protection = 0;
  reg [3:0] adr = 4'h0, sel = 4'h3;
  reg [31:0] wd = 32'h0, d;
  reg [15:0] cnt = 16'h0000;
  reg [7:0] b0 = 8'h00, b1 = 8'h00;
  wire [31:0] rdat;
  wire ack, p0, p1;
  wire [7:0] n0, n1;
  integer bad_count = 0, total_checks = 0, cyc_n = 0;
  pcts_trigger_select i_pcts_trigger_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .carrier_counter_i(cnt), .count_up_i(up), .carrier_peak_i(pk),
    .carrier_bottom_i(bt), .triangle_mode_i(tri_m), .emergency_protection_i(emergency_protection),
    .conversion_start_pulse0_o(p0), .conversion_start_pulse1_o(p1));
  pcts_adc_model i_pcts_adc_model (.clk_i(clk_i), .rst_i(rst_i), .start0_i(p0), .start1_i(p1),
    .count0_o(n0), .count1_o(n1));
  // Clock and a 20000-cycle ceiling well above the about 160 cycles the tests need.
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      end_sim;
    end
  end
  // One classic bus cycle; data is taken on the edge that sees ack.
  task acc(input w, input [3:0] a, input [31:0] v);
    begin
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= v;
      @(posedge clk_i);
      while (!ack) @(posedge clk_i);
      d = rdat;
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk_i);
    end
  endtask
  task tick(input [15:0] c, input u, input p, input b);
    begin
      cnt <= c; up <= u; pk <= p; bt <= b;
      @(posedge clk_i);
    end
  endtask
  task sweep(input integer a, input integer b);
    integer i;
    for (i = a; i != b + ((b > a) ? 1 : -1); i = i + ((b > a) ? 1 : -1)) tick(i[15:0], b > a, 0, 0);
  endtask
  // Conversions counted by the far side since the previous look.
  task expect_n(input [7:0] e0, input [7:0] e1);
    begin
      tick(cnt, up, 0, 0);
      repeat (3) @(posedge clk_i);
      `CHK(n0 - b0, e0)
      `CHK(n1 - b1, e1)
      b0 = n0;
      b1 = n1;
    end
  endtask
  task t_regs;
    begin
      acc(0, 4'h0, 0); `CHK(d, 32'h0)
      acc(0, 4'h4, 0); `CHK(d, 32'h0)
      acc(1, 4'h0, 32'hFFFF_00FF); acc(0, 4'h0, 0); `CHK(d, 32'h0000_00FF)
      acc(1, 4'h4, 32'hFFFF_FFFD); acc(0, 4'h4, 0); `CHK(d, 32'h1)
      acc(0, 4'h2, 0); `CHK(d, 32'h0)
      acc(1, 4'h4, 0);
      $display("register test done");
    end
  endtask
  task t_peak;
    begin
      acc(1, 4'h0, 32'h64); tick(8, 1, 1, 0); tick(7, 0, 0, 0); tick(0, 0, 0, 1); tick(1, 1, 0, 0);
      expect_n(1, 2);
      $display("peak test done");
    end
  endtask
  task t_saw;
    begin
      tri_m <= 0; acc(1, 4'h0, 32'h59); acc(1, 4'h8, 32'h10);
      sweep(0, 31); tick(31, 1, 1, 0); tick(0, 1, 0, 1);
      expect_n(1, 1);
      tri_m <= 1; $display("sawtooth test done");
    end
  endtask
  task t_both;
    begin
      acc(1, 4'h0, 32'hBB); acc(1, 4'h8, 1); acc(1, 4'hC, 3);
      sweep(0, 6); tick(6, 1, 1, 0); sweep(5, 0); tick(0, 0, 0, 1);
      expect_n(1, 2);
      $display("both-direction test done");
    end
  endtask
  task t_buf;
    begin
      acc(1, 4'h0, 32'h20); acc(1, 4'hC, 32'h10);
      acc(0, 4'hC, 0); `CHK(d, 32'h0000_0010)
      sweep(0, 7);
      expect_n(0, 1);
      tick(0, 1, 0, 1); sweep(0, 7);
      expect_n(0, 0);
      $display("buffered load test done");
    end
  endtask
  task t_emg;
    begin
      emergency_protection <= 1; acc(1, 4'h0, 32'h44); tick(7, 1, 1, 0);
      expect_n(0, 0);
      acc(1, 4'h4, 1); tick(7, 1, 1, 0);
      expect_n(1, 1);
      emergency_protection <= 0; $display("protection test done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs; t_peak; t_saw; t_both; t_buf; t_emg;
    end_sim;
  end
endmodule
